// >>> rtl/hall_mode_channel_ctrl.sv
// operating mode, trigger and channel configuration of the 3-axis sensor
//
// Overview of operation
// - hysteresis code n gives 2^(n+1) lsb
// - bit 4 picks low current or low noise
// - bit 3 set bypasses bus glitch filter
// - bit 2 picks command or pin trigger
// - one accepted trigger launches one conversion
// - running conversion finishes before new trigger
// - one surplus trigger is held while busy, further ones dropped
// - trigger source matters only in triggered modes
// - mode field: standby, sleep, continuous, wake-sleep
// - standby idles until a trigger event
// - leaving wake-sleep on wake_exit rewrites mode field to standby, unless a same-cycle host write wins
// - channel codes 1 to 7 are axis masks
// - channel code 0 disables all, reset default
// - codes 8 to 11 run three-sample sequences
// - codes 12, 13 add positive, negative diagnostic
// - codes 14, 15 run the self checks
// - sleep interval used only in wake-sleep mode
// - sleep codes 0 to 12 map to ms table
`timescale 1ns/1ps
`default_nettype none
module hall_mode_channel_ctrl
    import hall_cfg_pkg::*;
#(
    parameter int unsigned CYC_MS = CYC_PER_MS
) (
    input  wire logic        clock,        // system clock, 100 MHz
    input  wire logic        reset,        // synchronous, active high
    input  wire logic        reg_wr_en,    // register write strobe
    input  wire logic        reg_rd_en,    // register read strobe
    input  wire logic [7:0]  reg_addr,     // register offset
    input  wire logic [7:0]  reg_wdata,    // write data
    output logic [7:0]       reg_rdata,    // read data, one cycle later
    input  wire logic        cmd_trigger,  // trigger bit seen in a bus frame
    input  wire logic        int_pin_in,   // interrupt pin level, async
    input  wire logic        wake_exit,    // wake-sleep event ends duty cycle
    input  wire logic        conv_done,    // converter finished a conversion
    output logic             conv_start,   // one-cycle conversion launch
    output logic             conv_busy,    // conversion in progress
    output logic [1:0]       mode_out,     // current operating mode
    output logic             sleeping,     // low-power wait in progress
    output sensor_cfg_t      sensor_cfg    // decoded front-end setup
);

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_CONVERT = 2'b01,
        ST_SLEEP   = 2'b10
    } seq_state_t;

    // channel code decode, used for the live config output
    function automatic sensor_cfg_t decode_cfg(input logic [7:0] opctl,
                                               input logic [7:0] chsel);
        sensor_cfg_t c;
        logic [3:0]  ch;
        c  = '0;
        ch = chsel[CHAN_MSB:CHAN_LSB];
        c.hyst_lsb      = 9'h002 << opctl[HYST_MSB:HYST_LSB];
        c.low_noise     = opctl[PWR_NOISE_BIT];
        c.glitch_bypass = opctl[GLITCH_BIT];
        if (!ch[3]) begin
            c.axis_mask = ch[2:0];
        end else begin
            unique case (ch[2:1])
                2'b00, 2'b01: begin
                    c.seq_en = 1'b1;
                    c.seq    = axis_seq_t'(ch[1:0]);
                    unique case (ch[1:0])
                        2'b00: c.axis_mask = 3'h3;
                        2'b01: c.axis_mask = 3'h3;
                        2'b10: c.axis_mask = 3'h6;
                        2'b11: c.axis_mask = 3'h5;
                    endcase
                end
                2'b10: begin
                    c.axis_mask = 3'h7;
                    c.diag_pos  = !ch[0];
                    c.diag_neg  = ch[0];
                end
                2'b11: begin
                    c.check_resist = !ch[0];
                    c.check_offset = ch[0];
                end
            endcase
        end
        return c;
    endfunction

    logic [7:0]  opctl_r;
    logic [7:0]  chsel_r;
    logic [7:0]  opctl_nxt;
    seq_state_t  state_r;
    seq_state_t  state_nxt;
    logic        pending_r;
    logic        pending_nxt;
    logic        pin_meta_r;
    logic        pin_sync_r;
    logic        pin_prev_r;
    logic        sleep_go_r;
    logic        sleep_expired;

    // ---------------- register access ----------------
    wire hit_opctl = reg_addr == OPCTL_ADDR;
    wire hit_chsel = reg_addr == CHSEL_ADDR;
    wire wr_opctl  = reg_wr_en && hit_opctl;
    wire wr_chsel  = reg_wr_en && hit_chsel;

    wire [7:0] rd_mux = hit_opctl ? opctl_r :
                        hit_chsel ? chsel_r : UNMAPPED_RDATA;

    wire op_mode_t mode     = op_mode_t'(opctl_r[MODE_MSB:MODE_LSB]);
    wire           pin_src  = opctl_r[TRIG_SRC_BIT];
    wire [3:0]     sleep_cd = chsel_r[SLEEP_MSB:SLEEP_LSB];

    // hardware leaves wake-sleep for standby; a host write that lands in
    // the same cycle wins so software is never overridden silently
    wire hw_to_standby = (mode == MODE_WAKE) && wake_exit;

    always_comb begin
        opctl_nxt = opctl_r;
        if (wr_opctl) begin
            opctl_nxt = reg_wdata;
        end else if (hw_to_standby) begin
            opctl_nxt[MODE_MSB:MODE_LSB] = MODE_STANDBY;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            opctl_r <= OPCTL_RESET;
            chsel_r <= CHSEL_RESET;
        end else begin
            opctl_r <= opctl_nxt;
            if (wr_chsel) begin
                chsel_r <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd_en) begin
            reg_rdata <= rd_mux;
        end
    end

    // ---------------- trigger sources ----------------
    // pin passes two flops before the edge detector looks at it
    always_ff @(posedge clock) begin
        if (reset) begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
            pin_prev_r <= 1'b0;
        end else begin
            pin_meta_r <= int_pin_in;
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    wire pin_rise = pin_sync_r && !pin_prev_r;
    wire trig_raw = pin_src ? pin_rise : cmd_trigger;
    // only standby starts conversions on a trigger
    wire trig_evt = (mode == MODE_STANDBY) && trig_raw;

    // ---------------- conversion sequencer ----------------
    wire self_run = (mode == MODE_CONT) || (mode == MODE_WAKE);
    // a held trigger only counts while still in standby, so a mode
    // change between conv_done and relaunch cannot start a conversion
    wire launch   = (state_r == ST_IDLE) &&
                    (self_run || trig_evt ||
                     (pending_r && mode == MODE_STANDBY));

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (launch) begin
                    state_nxt = ST_CONVERT;
                end
            end
            ST_CONVERT: begin
                if (conv_done) begin
                    // wake-sleep rests between conversions
                    state_nxt = (mode == MODE_WAKE) ? ST_SLEEP : ST_IDLE;
                end
            end
            ST_SLEEP: begin
                if (mode != MODE_WAKE || sleep_expired) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // at most one trigger is held while converting; more are dropped
    always_comb begin
        pending_nxt = pending_r;
        if (mode != MODE_STANDBY || launch) begin
            pending_nxt = 1'b0;
        end
        if (trig_evt && state_r != ST_IDLE) begin
            pending_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_r    <= ST_IDLE;
            pending_r  <= 1'b0;
            conv_start <= 1'b0;
            conv_busy  <= 1'b0;
            sleep_go_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            pending_r  <= pending_nxt;
            conv_start <= launch;
            conv_busy  <= state_nxt == ST_CONVERT;
            sleep_go_r <= state_r == ST_CONVERT && state_nxt == ST_SLEEP;
        end
    end

    // ---------------- sleep interval ----------------
    // interval code is sampled at sleep entry; a rewrite mid-sleep
    // applies to the next rest, which keeps the timer simple
    sleep_interval_timer #(
        .CYC_MS (CYC_MS)
    ) u_sleep_timer (
        .clock   (clock),
        .reset   (reset),
        .start   (sleep_go_r),
        .abort   (mode != MODE_WAKE),
        .code    (sleep_cd),
        .expired (sleep_expired)
    );

    // ---------------- outputs ----------------
    always_ff @(posedge clock) begin
        if (reset) begin
            mode_out   <= MODE_STANDBY;
            sleeping   <= 1'b0;
            sensor_cfg <= '0;
        end else begin
            mode_out   <= opctl_nxt[MODE_MSB:MODE_LSB];
            sleeping   <= state_nxt == ST_SLEEP;
            // configuration follows the registers live, so a write
            // during a conversion changes the setup it runs with
            sensor_cfg <= decode_cfg(opctl_nxt, chsel_r);
        end
    end

endmodule
`default_nettype wire

// >>> common/hall_cfg_pkg.sv
// shared constants and types for the sensor mode and channel configuration
package hall_cfg_pkg;

    // register offsets and reset values
    localparam logic [7:0] OPCTL_ADDR      = 8'h01;
    localparam logic [7:0] CHSEL_ADDR      = 8'h02;
    localparam logic [7:0] OPCTL_RESET     = 8'h00;
    localparam logic [7:0] CHSEL_RESET     = 8'h00;
    localparam logic [7:0] UNMAPPED_RDATA  = 8'h00;

    // operation_control field positions
    localparam int HYST_MSB       = 7;
    localparam int HYST_LSB       = 5;
    localparam int PWR_NOISE_BIT  = 4;
    localparam int GLITCH_BIT     = 3;
    localparam int TRIG_SRC_BIT   = 2;
    localparam int MODE_MSB       = 1;
    localparam int MODE_LSB       = 0;

    // channel_and_sleep_select field positions
    localparam int CHAN_MSB       = 7;
    localparam int CHAN_LSB       = 4;
    localparam int SLEEP_MSB      = 3;
    localparam int SLEEP_LSB      = 0;

    // timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int MS_NS          = 1000000;
    localparam int CYC_PER_MS     = MS_NS / CLK_PERIOD_NS;
    localparam int SLEEP_CODES    = 13;

    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_SLEEP   = 2'b01,
        MODE_CONT    = 2'b10,
        MODE_WAKE    = 2'b11
    } op_mode_t;

    typedef enum logic [1:0] {
        SEQ_XYX = 2'b00,
        SEQ_YXY = 2'b01,
        SEQ_YZY = 2'b10,
        SEQ_XZX = 2'b11
    } axis_seq_t;

    // configuration handed to the analog front end and converter
    typedef struct packed {
        logic [8:0]  hyst_lsb;      // hysteresis in 12-bit lsb
        logic        low_noise;
        logic        glitch_bypass;
        logic [2:0]  axis_mask;     // x, y, z in bits 0..2
        logic        seq_en;
        axis_seq_t   seq;
        logic        diag_pos;
        logic        diag_neg;
        logic        check_resist;  // hall resistance plus adc check
        logic        check_offset;  // hall offset plus front-end check
    } sensor_cfg_t;

    // sleep interval in ms per code; codes above 12 use the last entry
    function automatic logic [14:0] sleep_ms(input logic [3:0] code);
        logic [14:0] ms;
        ms = 15'd20000;
        case (code)
            4'h0: ms = 15'd1;
            4'h1: ms = 15'd5;
            4'h2: ms = 15'd10;
            4'h3: ms = 15'd15;
            4'h4: ms = 15'd20;
            4'h5: ms = 15'd30;
            4'h6: ms = 15'd50;
            4'h7: ms = 15'd100;
            4'h8: ms = 15'd500;
            4'h9: ms = 15'd1000;
            4'ha: ms = 15'd2000;
            4'hb: ms = 15'd5000;
            default: ms = 15'd20000;
        endcase
        return ms;
    endfunction

endpackage

// >>> rtl/sleep_interval_timer.sv
// millisecond interval timer for the duty-cycled wake and sleep mode
`timescale 1ns/1ps
`default_nettype none
module sleep_interval_timer
    import hall_cfg_pkg::*;
#(
    parameter int unsigned CYC_MS = CYC_PER_MS
) (
    input  wire logic        clock,     // system clock
    input  wire logic        reset,     // synchronous, active high
    input  wire logic        start,     // load interval and run
    input  wire logic        abort,     // stop without expiry
    input  wire logic [3:0]  code,      // sleep interval code
    output logic             expired    // one-cycle pulse at interval end
);

    logic [31:0] div_r;
    logic [14:0] ms_left_r;
    logic        run_r;
    wire         ms_tick = run_r && (div_r == CYC_MS - 1);
    wire         last_ms = ms_left_r == 15'd1;

    // divider restarts on each start so the first ms is whole
    always_ff @(posedge clock) begin
        if (reset || start || !run_r || ms_tick) begin
            div_r <= 32'h0000_0000;
        end else begin
            div_r <= div_r + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock) begin
        if (reset || abort) begin
            run_r     <= 1'b0;
            ms_left_r <= 15'h0000;
            expired   <= 1'b0;
        end else if (start) begin
            run_r     <= 1'b1;
            ms_left_r <= sleep_ms(code);
            expired   <= 1'b0;
        end else begin
            expired <= ms_tick && last_ms;
            if (ms_tick) begin
                ms_left_r <= ms_left_r - 15'd1;
                run_r     <= !last_ms;
            end
        end
    end

endmodule
`default_nettype wire

// >>> testbench/hall_ctrl_properties.sv
// port-level assertions for the mode and channel control block
`timescale 1ns/1ps
`default_nettype none
module hall_ctrl_properties
    import hall_cfg_pkg::*;
#(
    parameter int unsigned CYC_MS = CYC_PER_MS
) (
    input wire logic        clock,       // system clock
    input wire logic        reset,       // sync reset
    input wire logic        reg_wr_en,   // write strobe
    input wire logic        reg_rd_en,   // read strobe
    input wire logic [7:0]  reg_addr,    // offset
    input wire logic [7:0]  reg_wdata,   // write data
    input wire logic [7:0]  reg_rdata,   // read data
    input wire logic        cmd_trigger, // frame trigger
    input wire logic        int_pin_in,  // pin level
    input wire logic        wake_exit,   // duty-cycle end
    input wire logic        conv_done,   // converter done
    input wire logic        conv_start,  // launch pulse
    input wire logic        conv_busy,   // converting
    input wire logic [1:0]  mode_out,    // mode field
    input wire logic        sleeping,    // resting
    input wire sensor_cfg_t sensor_cfg   // decoded setup
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire logic       wr_op = reg_wr_en && reg_addr == OPCTL_ADDR;
    wire logic [2:0] hyst  = reg_wdata[HYST_MSB:HYST_LSB];
    wire logic [1:0] wmode = reg_wdata[MODE_MSB:MODE_LSB];
    wire logic       pn    = reg_wdata[PWR_NOISE_BIT];
    wire logic       gb    = reg_wdata[GLITCH_BIT];
    // decode updates with the register; one quiet cycle keeps it for the check
    sequence op_then_quiet;
        wr_op ##1 !wr_op;
    endsequence
    sequence stays_sleep;
        mode_out == MODE_SLEEP ##1 mode_out == MODE_SLEEP;
    endsequence
    sequence not_wake;
        mode_out != MODE_WAKE ##1 mode_out != MODE_WAKE;
    endsequence

    AST_START_PULSE: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    AST_START_BUSY: assert property (conv_start |-> conv_busy)
        else $error("start without busy");
    AST_NO_START_BUSY: assert property (
        conv_busy && !conv_done |=> !conv_start)
        else $error("start during conversion");
    AST_MODE_WR: assert property (wr_op |=> mode_out == $past(wmode))
        else $error("mode not written");
    AST_EXIT_STBY: assert property (
        wake_exit && mode_out == MODE_WAKE && !wr_op
        |=> mode_out == MODE_STANDBY)
        else $error("wake exit kept mode");
    AST_HYST: assert property (
        op_then_quiet |=> sensor_cfg.hyst_lsb == (9'd2 << $past(hyst, 2)))
        else $error("hysteresis decode wrong");
    AST_PWR_GLITCH: assert property (op_then_quiet |=>
        sensor_cfg.low_noise == $past(pn, 2)
        && sensor_cfg.glitch_bypass == $past(gb, 2))
        else $error("power or filter bit wrong");
    AST_SLEEP_NO_START: assert property (stays_sleep |-> !conv_start)
        else $error("start in sleep mode");
    AST_REST_WAKE_ONLY: assert property (not_wake |-> !sleeping)
        else $error("rest outside wake mode");
endmodule

bind hall_mode_channel_ctrl hall_ctrl_properties #(.CYC_MS(CYC_MS)) u_props (
    .clock(clock), .reset(reset), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .cmd_trigger(cmd_trigger),
    .int_pin_in(int_pin_in), .wake_exit(wake_exit), .conv_done(conv_done),
    .conv_start(conv_start), .conv_busy(conv_busy), .mode_out(mode_out),
    .sleeping(sleeping), .sensor_cfg(sensor_cfg));
`default_nettype wire

// >>> testbench/hall_host_model.sv
// host side: register strobes and conversion triggers
`timescale 1ns/1ps
`default_nettype none
module hall_host_model (
    input  wire logic       clock,       // system clock
    output logic            reg_wr_en,   // write strobe
    output logic            reg_rd_en,   // read strobe
    output logic [7:0]      reg_addr,    // offset
    output logic [7:0]      reg_wdata,   // write data
    output logic            cmd_trigger, // frame trigger
    output logic            int_pin_in,  // trigger pin
    input  wire logic [7:0] reg_rdata    // read data
);
    initial begin
        {reg_wr_en, reg_rd_en, cmd_trigger, int_pin_in} = 4'h0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // callers never send sleep codes 13 to 15
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr_en = 1'b0;
        reg_wdata = ~d; // stale data must not look valid
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd_en = 1'b0;
        d = reg_rdata;
    endtask
    task automatic cmd();
        @(negedge clock);
        cmd_trigger = 1'b1;
        @(negedge clock);
        cmd_trigger = 1'b0;
    endtask
    // held long enough for the pin synchroniser
    task automatic pin();
        @(negedge clock);
        int_pin_in = 1'b1;
        repeat (4) @(negedge clock);
        int_pin_in = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> testbench/test_hall_mode_channel_ctrl.sv
// self-checking bench for the mode and channel control block
`timescale 1ns/1ps
`default_nettype none
module test_hall_mode_channel_ctrl
    import hall_cfg_pkg::*;
;
    localparam int CYC = 10;
    typedef struct packed {
        logic [3:0] code;
        logic [9:0] exp;
        logic [9:0] care;
    } row_t;
    // low ten cfg bits: mask, seq_en, seq, diag+, diag-, checks
    row_t rows[16] = '{
        '{4'h0, 10'h000, 10'h3ff}, '{4'h1, 10'h080, 10'h3ff},
        '{4'h2, 10'h100, 10'h3ff}, '{4'h3, 10'h180, 10'h3ff},
        '{4'h4, 10'h200, 10'h3ff}, '{4'h5, 10'h280, 10'h3ff},
        '{4'h6, 10'h300, 10'h3ff}, '{4'h7, 10'h380, 10'h3ff},
        '{4'h8, 10'h040, 10'h07f}, '{4'h9, 10'h050, 10'h07f},
        '{4'ha, 10'h060, 10'h07f}, '{4'hb, 10'h070, 10'h07f},
        '{4'hc, 10'h388, 10'h3ff}, '{4'hd, 10'h384, 10'h3ff},
        '{4'he, 10'h002, 10'h07f}, '{4'hf, 10'h001, 10'h07f}};
    logic        clock, reset, wake_exit, conv_done;
    logic        reg_wr_en, reg_rd_en, cmd_trigger, int_pin_in;
    logic        conv_start, conv_busy, sleeping;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, op;
    logic [1:0]  mode_out;
    sensor_cfg_t sensor_cfg;
    int          n_mismatch, tests_run, n_start, cyc, n0, k;

    hall_mode_channel_ctrl #(.CYC_MS(CYC)) DUT (
        .clock(clock), .reset(reset), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .cmd_trigger(cmd_trigger),
        .int_pin_in(int_pin_in), .wake_exit(wake_exit),
        .conv_done(conv_done), .conv_start(conv_start),
        .conv_busy(conv_busy), .mode_out(mode_out), .sleeping(sleeping),
        .sensor_cfg(sensor_cfg));
    hall_host_model host (
        .clock(clock), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .cmd_trigger(cmd_trigger), .int_pin_in(int_pin_in),
        .reg_rdata(reg_rdata));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (conv_start === 1'b1)
            n_start++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic done();
        @(negedge clock);
        conv_done = 1'b1;
        @(negedge clock);
        conv_done = 1'b0;
    endtask
    task automatic wait_start(input int n);
        for (int i = 0; i < 100 && n_start < n; i++)
            @(negedge clock);
        chk(16'(n_start), 16'(n));
    endtask

    initial begin
        {reset, wake_exit, conv_done} = 3'b100;
        repeat (16) @(negedge clock);
        reset = 1'b0;
        chk(16'(sensor_cfg[9:0]), 16'h0);
        host.rd(OPCTL_ADDR, d);
        chk(16'(d), 16'(OPCTL_RESET));
        host.rd(CHSEL_ADDR, d);
        chk(16'(d), 16'(CHSEL_RESET));
        host.wr(8'h03, 8'hff);
        host.rd(8'h03, d);
        chk(16'(d), 16'(UNMAPPED_RDATA));
        foreach (rows[i]) begin
            op = {rows[i].code[2:0], rows[i].code[3], rows[i].code[0], 3'h0};
            host.wr(OPCTL_ADDR, op);
            host.wr(CHSEL_ADDR, {rows[i].code, 4'(i % 13)});
            repeat (3) @(negedge clock);
            chk(16'(sensor_cfg[9:0] & rows[i].care), 16'(rows[i].exp));
            chk(16'(sensor_cfg[20:10]), 16'({9'd2 << op[7:5], op[4:3]}));
            host.rd(OPCTL_ADDR, d);
            chk(16'(d), 16'(op));
            host.rd(CHSEL_ADDR, d);
            chk(16'(d), 16'({rows[i].code, 4'(i % 13)}));
        end
        // trigger bursts while converting: one kept, rest dropped
        host.wr(OPCTL_ADDR, 8'h00);
        n0 = n_start;
        host.cmd();
        wait_start(n0 + 1);
        repeat (3) host.cmd();
        chk(16'(n_start), 16'(n0 + 1));
        chk(16'(conv_busy), 16'h1);
        done();
        repeat (6) @(negedge clock);
        chk(16'(n_start), 16'(n0 + 2));
        done();
        repeat (6) @(negedge clock);
        chk(16'(n_start), 16'(n0 + 2));
        chk(16'(conv_busy), 16'h0);
        host.wr(OPCTL_ADDR, 8'h04);
        host.cmd();
        repeat (6) @(negedge clock);
        chk(16'(n_start), 16'(n0 + 2));
        host.pin();
        wait_start(n0 + 3);
        done();
        host.wr(OPCTL_ADDR, 8'h02);
        wait_start(n0 + 4);
        done();
        wait_start(n0 + 5);
        host.wr(OPCTL_ADDR, 8'h01);
        done();
        host.cmd();
        repeat (8) @(negedge clock);
        chk(16'(n_start), 16'(n0 + 5));
        // sleep code 1 is 5 ms of rest
        host.wr(CHSEL_ADDR, 8'h11);
        host.wr(OPCTL_ADDR, 8'h03);
        wait_start(n0 + 6);
        done();
        repeat (3) @(negedge clock);
        chk(16'(sleeping), 16'h1);
        for (k = 0; k < 200 && n_start == n0 + 6; k++)
            @(negedge clock);
        chk(16'(k >= 5 * CYC - 5 && k <= 5 * CYC + 5), 16'h1);
        done();
        repeat (3) @(negedge clock);
        wake_exit = 1'b1;
        @(negedge clock);
        wake_exit = 1'b0;
        @(negedge clock);
        chk(16'(mode_out), 16'(MODE_STANDBY));
        chk(16'(sleeping), 16'h0);
        host.rd(OPCTL_ADDR, d);
        chk(16'(d), 16'h0);
        // reset in mid-run while a continuous conversion is running
        host.wr(OPCTL_ADDR, 8'hf6);
        host.wr(CHSEL_ADDR, 8'h52);
        reset = 1'b1;
        repeat (3) @(negedge clock);
        reset = 1'b0;
        chk(16'(mode_out), 16'(MODE_STANDBY));
        chk(16'(sensor_cfg[20:10]), 16'h0);
        chk(16'(sensor_cfg[9:0]), 16'h0);
        chk(16'(conv_busy), 16'h0);
        host.rd(OPCTL_ADDR, d);
        chk(16'(d), 16'(OPCTL_RESET));
        host.rd(CHSEL_ADDR, d);
        chk(16'(d), 16'(CHSEL_RESET));
        summarize();
    end
endmodule
`default_nettype wire
